//--- shared/lic_defs.svh
// Constants of the level interrupt controller
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LIC_NSRC 31
`define LIC_NLVL 8
`define LIC_GRP_B_LO 2
`define LIC_GRP_C_LO 5

// ----------------------------------------
// First source index of each level
// ----------------------------------------
`define LIC_L1_LO 2
`define LIC_L2_LO 3
`define LIC_L3_LO 5
`define LIC_L4_LO 9
`define LIC_L5_LO 11
`define LIC_L6_LO 15
`define LIC_L7_LO 23

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define LIC_VEC_TMR 8'hCE
`define LIC_VEC_SER 8'hE4
`define LIC_VEC_P4 8'hB0
`define LIC_VEC_STEP 2

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LIC_OFS_REQ 8'h00
`define LIC_OFS_MASK 8'h04
`define LIC_OFS_PRIO 8'h08
`define LIC_OFS_SYM 8'h0C
`define LIC_OFS_STAT 8'h10
`define LIC_OFS_IMSK 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define LIC_SYM_GIE 0
`define LIC_IPR_GA 7
`define LIC_IPR_GB 4
`define LIC_IPR_GC 1
`define LIC_IPR_A 0
`define LIC_IPR_B 2
`define LIC_IPR_BS 3
`define LIC_IPR_C 5
`define LIC_IPR_CS 6
`define LIC_RST8 8'h00
`define LIC_RST32 32'h0000_0000
`define LIC_HTRANS_NSEQ_BIT 1

`endif

//--- shared/lic_pkg.sv
// Types of the level interrupt controller
`default_nettype none
`include "lic_defs.svh"

package lic_pkg;

   typedef logic [`LIC_NLVL-1:0] lic_lvl_t;
   typedef logic [`LIC_NSRC-1:0] lic_srcv_t;
   typedef logic [3:0] lic_rank_t;

   // Per-source pending and enable bits from the peripherals
   typedef struct packed {
      lic_srcv_t pend;
      lic_srcv_t en;
   } lic_src_s;

   // Request offered to the CPU core
   typedef struct packed {
      logic req;
      logic [2:0] level;
      logic [4:0] src;
      logic [7:0] vector;
   } lic_cpu_s;

endpackage : lic_pkg

`default_nettype wire

//--- hw/lic_enc.sv
// Lowest-index encoder used for the fixed in-level order
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"

module lic_enc
   import lic_pkg::*;
(
   input wire lic_srcv_t req,  // Competing sources
   output logic valid,         // Any source competing
   output logic [4:0] idx      // Winning source index
);

   always_comb begin
      valid = 1'b0;
      idx = 5'h0;
      for (int i = `LIC_NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx = 5'(i);
         end
      end
   end

endmodule : lic_enc

`default_nettype wire

//--- hw/lic_prio.sv
// Level priority resolver with grouped programmable order
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"

module lic_prio
   import lic_pkg::*;
(
   input wire lic_lvl_t act,            // Levels requesting service
   input wire logic [7:0] level_priority_reg,          // Level priority register
   output logic win_valid,              // A level wins
   output logic [2:0] win_lvl,          // Winning level
   output lic_rank_t [7:0] rank         // Rank per level, 0 is highest
);

   logic [1:0] pa;
   logic [1:0] pb;
   logic [1:0] pc;
   logic [1:0] sub [8];
   lic_rank_t best;

   always_comb begin
      // Group order from three scattered bits
      unique case ({level_priority_reg[`LIC_IPR_GA], level_priority_reg[`LIC_IPR_GB], level_priority_reg[`LIC_IPR_GC]})
         3'h1: begin pa = 2'h2; pb = 2'h0; pc = 2'h1; end
         3'h2: begin pa = 2'h0; pb = 2'h1; pc = 2'h2; end
         3'h3: begin pa = 2'h1; pb = 2'h0; pc = 2'h2; end
         3'h4: begin pa = 2'h1; pb = 2'h2; pc = 2'h0; end
         3'h5: begin pa = 2'h2; pb = 2'h1; pc = 2'h0; end
         3'h6: begin pa = 2'h0; pb = 2'h2; pc = 2'h1; end
         default: begin pa = 2'h0; pb = 2'h1; pc = 2'h2; end
      endcase
      // Order inside group A (0,1), B (2..4), C (5..7)
      sub[0] = {1'b0, level_priority_reg[`LIC_IPR_A]};
      sub[1] = {1'b0, ~level_priority_reg[`LIC_IPR_A]};
      sub[2] = level_priority_reg[`LIC_IPR_B] ? 2'h2 : 2'h0;
      sub[3] = {1'b0, ~level_priority_reg[`LIC_IPR_B]} + {1'b0, level_priority_reg[`LIC_IPR_BS]};
      sub[4] = {1'b0, ~level_priority_reg[`LIC_IPR_B]} + {1'b0, ~level_priority_reg[`LIC_IPR_BS]};
      sub[5] = level_priority_reg[`LIC_IPR_C] ? 2'h2 : 2'h0;
      sub[6] = {1'b0, ~level_priority_reg[`LIC_IPR_C]} + {1'b0, level_priority_reg[`LIC_IPR_CS]};
      sub[7] = {1'b0, ~level_priority_reg[`LIC_IPR_C]} + {1'b0, ~level_priority_reg[`LIC_IPR_CS]};
      for (int l = 0; l < `LIC_NLVL; l++) begin
         if (l < `LIC_GRP_B_LO) begin
            rank[l] = {pa, sub[l]};
         end else if (l < `LIC_GRP_C_LO) begin
            rank[l] = {pb, sub[l]};
         end else begin
            rank[l] = {pc, sub[l]};
         end
      end
      // Smallest rank value wins
      win_valid = 1'b0;
      win_lvl = 3'h0;
      best = 4'hF;
      for (int l = 0; l < `LIC_NLVL; l++) begin
         if (act[l] && (!win_valid || rank[l] < best)) begin
            win_valid = 1'b1;
            win_lvl = 3'(l);
            best = rank[l];
         end
      end
   end

endmodule : lic_prio

`default_nettype wire

//--- hw/lic_ctrl.sv
// Level interrupt controller with AHB-Lite register slave
//
// Summary of operation
// - Priority value zero is the highest priority
// - Lowest vector address wins inside a level
// - Enable op turns the whole structure on
// - Disable op stops all servicing at once; here cpu_o.req is low two clocks after the op, irq_o ignores global enable
// - Both ops write global enable bit zero
// - Mask register has one bit per level
// - Groups: A levels 0-1, B 2-4, C 5-7
// - Request register is read-only, per level
// - Mode register holds fast, enable, interface controls
// - Source enable, mask and global enable needed
// - Timers route to levels zero through three
// - Ports to 6 and 7, serial 4, UARTs 5
// - Request bit n is level n, reset zero
// - Mask one enables level, zero masks it
// - Reset clears mode bits zero and one
// - Priority bits 7,4,1 order the groups
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"

module lic_ctrl
   import lic_pkg::*;
(
   input wire logic hclk,               // Bus clock
   input wire logic hresetn,            // Async reset, active low
   input wire logic hsel,               // Slave select
   input wire logic [31:0] haddr,       // Byte address
   input wire logic [1:0] htrans,       // Transfer type
   input wire logic hwrite,             // Write when high
   input wire logic [2:0] hsize,        // Transfer size, word only
   input wire logic [31:0] hwdata,      // Write data
   input wire logic hready,             // Bus ready
   output logic hreadyout,              // Slave ready
   output logic [31:0] hrdata,          // Read data
   output logic hresp,                  // Always OKAY
   input wire lic_src_s src_i,          // Peripheral pending and enable bits
   input wire logic global_enable_op,   // Enable instruction pulse
   input wire logic global_disable_op,  // Disable instruction pulse
   output lic_cpu_s cpu_o,              // Request to the CPU core
   output logic irq_o                   // Level event interrupt
);

   // ----------------------------------------
   // Source to level routing
   // ----------------------------------------
   function automatic logic [2:0] src_level(input int i);
      if (i < `LIC_L1_LO) return 3'h0;
      else if (i < `LIC_L2_LO) return 3'h1;
      else if (i < `LIC_L3_LO) return 3'h2;
      else if (i < `LIC_L4_LO) return 3'h3;
      else if (i < `LIC_L5_LO) return 3'h4;
      else if (i < `LIC_L6_LO) return 3'h5;
      else if (i < `LIC_L7_LO) return 3'h6;
      else return 3'h7;
   endfunction : src_level

   function automatic lic_srcv_t lvl_sources(input logic [2:0] l);
      lic_srcv_t m;
      m = '0;
      for (int i = 0; i < `LIC_NSRC; i++) begin
         m[i] = (src_level(i) == l);
      end
      return m;
   endfunction : lvl_sources

   function automatic logic [7:0] src_vector(input logic [4:0] s);
      if (s < 5'(`LIC_L4_LO)) return `LIC_VEC_TMR + 8'(`LIC_VEC_STEP * s);
      else if (s < 5'(`LIC_L7_LO)) return `LIC_VEC_SER + 8'(`LIC_VEC_STEP * (s - 5'(`LIC_L4_LO)));
      else return `LIC_VEC_P4 + 8'(`LIC_VEC_STEP * (s - 5'(`LIC_L7_LO)));
   endfunction : src_vector

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lic_srcv_t act_src;
   lic_lvl_t level_pend;
   lic_lvl_t gated;
   lic_lvl_t events;
   lic_rank_t [7:0] rank;
   logic win_valid;
   logic [2:0] win_lvl;
   logic enc_valid;
   logic [4:0] enc_idx;
   logic take;
   logic wr_en;

   lic_lvl_t level_req_q, level_req_d;
   lic_lvl_t level_mask_reg_q, level_mask_reg_d;
   logic [7:0] level_priority_reg_q, level_priority_reg_d;
   logic [7:0] system_mode_reg_q, system_mode_reg_d;
   lic_lvl_t stat_q, stat_d;
   lic_lvl_t imask_q, imask_d;
   logic ap_valid_q, ap_valid_d;
   logic ap_write_q, ap_write_d;
   logic [7:0] ap_addr_q, ap_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   lic_cpu_s cpu_q, cpu_d;

   // ----------------------------------------
   // Level collection
   // ----------------------------------------
   assign act_src = src_i.pend & src_i.en;

   for (genvar l = 0; l < `LIC_NLVL; l++) begin : g_lvl
      assign level_pend[l] = |(act_src & lvl_sources(3'(l)));
   end

   assign gated = level_req_q & level_mask_reg_q & {`LIC_NLVL{system_mode_reg_q[`LIC_SYM_GIE]}};
   assign events = level_req_d & ~level_req_q;

   lic_prio u_prio (
      .act(gated),
      .level_priority_reg(level_priority_reg_q),
      .win_valid(win_valid),
      .win_lvl(win_lvl),
      .rank(rank)
   );

   lic_enc u_enc (
      .req(act_src & lvl_sources(win_lvl)),
      .valid(enc_valid),
      .idx(enc_idx)
   );

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   assign take = hsel && htrans[`LIC_HTRANS_NSEQ_BIT] && hready;
   assign wr_en = ap_valid_q && ap_write_q;

   always_comb begin
      ap_valid_d = take;
      ap_write_d = take && hwrite;
      ap_addr_d = take ? haddr[7:0] : ap_addr_q;
      hrdata_d = hrdata_q;
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            `LIC_OFS_REQ: hrdata_d = {24'h00_0000, level_req_q};
            `LIC_OFS_MASK: hrdata_d = {24'h00_0000, level_mask_reg_q};
            `LIC_OFS_PRIO: hrdata_d = {24'h00_0000, level_priority_reg_q};
            `LIC_OFS_SYM: hrdata_d = {24'h00_0000, system_mode_reg_q};
            `LIC_OFS_STAT: hrdata_d = {24'h00_0000, stat_q};
            `LIC_OFS_IMSK: hrdata_d = {24'h00_0000, imask_q};
            default: hrdata_d = `LIC_RST32;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q <= `LIC_RST8;
         hrdata_q <= `LIC_RST32;
      end else begin
         ap_valid_q <= ap_valid_d;
         ap_write_q <= ap_write_d;
         ap_addr_q <= ap_addr_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // ----------------------------------------
   // Control and status registers
   // ----------------------------------------
   always_comb begin
      level_req_d = level_pend;
      level_mask_reg_d = level_mask_reg_q;
      level_priority_reg_d = level_priority_reg_q;
      system_mode_reg_d = system_mode_reg_q;
      imask_d = imask_q;
      stat_d = stat_q;
      if (wr_en) begin
         unique case (ap_addr_q)
            `LIC_OFS_MASK: level_mask_reg_d = hwdata[7:0];
            `LIC_OFS_PRIO: level_priority_reg_d = hwdata[7:0];
            `LIC_OFS_SYM: system_mode_reg_d = hwdata[7:0];
            `LIC_OFS_STAT: stat_d = stat_q & ~hwdata[7:0];
            `LIC_OFS_IMSK: imask_d = hwdata[7:0];
            default: begin
            end
         endcase
      end
      // Instruction ops override a same-cycle bus write; disable wins
      if (global_disable_op) begin
         system_mode_reg_d[`LIC_SYM_GIE] = 1'b0;
      end else if (global_enable_op) begin
         system_mode_reg_d[`LIC_SYM_GIE] = 1'b1;
      end
      // A new level event beats a same-cycle clear
      stat_d = stat_d | events;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_req_q <= `LIC_RST8;
         level_mask_reg_q <= `LIC_RST8;
         level_priority_reg_q <= `LIC_RST8;
         system_mode_reg_q <= `LIC_RST8;
         stat_q <= `LIC_RST8;
         imask_q <= `LIC_RST8;
      end else begin
         level_req_q <= level_req_d;
         level_mask_reg_q <= level_mask_reg_d;
         level_priority_reg_q <= level_priority_reg_d;
         system_mode_reg_q <= system_mode_reg_d;
         stat_q <= stat_d;
         imask_q <= imask_d;
      end
   end

   assign irq_o = |(stat_q & imask_q);

   // ----------------------------------------
   // Request to the CPU
   // ----------------------------------------
   always_comb begin
      cpu_d.req = win_valid && enc_valid;
      cpu_d.level = win_lvl;
      cpu_d.src = enc_idx;
      cpu_d.vector = src_vector(enc_idx);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_q <= '0;
      end else begin
         cpu_q <= cpu_d;
      end
   end

   assign cpu_o = cpu_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic prio_bad;
   always_comb begin
      prio_bad = 1'b0;
      for (int l = 0; l < `LIC_NLVL; l++) begin
         if (win_valid && gated[l] && rank[l] < rank[win_lvl]) prio_bad = 1'b1;
      end
   end

   a_prio_inverse: assert property (@(posedge hclk) disable iff (!hresetn) !prio_bad)
      else $error("higher priority level was passed over");

   a_in_level_low: assert property (@(posedge hclk) disable iff (!hresetn)
      enc_valid |-> ((act_src & lvl_sources(win_lvl) & ((31'h1 << enc_idx) - 31'h1)) == '0))
      else $error("in-level winner is not the lowest vector");

   a_enable_op: assert property (@(posedge hclk) disable iff (!hresetn)
      global_enable_op && !global_disable_op |=> system_mode_reg_q[`LIC_SYM_GIE])
      else $error("enable op did not set global enable");

   a_disable_stops: assert property (@(posedge hclk) disable iff (!hresetn)
      global_disable_op |-> ##2 !cpu_o.req)
      else $error("request offered after disable op");

   a_disable_wins: assert property (@(posedge hclk) disable iff (!hresetn)
      global_disable_op |=> !system_mode_reg_q[`LIC_SYM_GIE])
      else $error("disable op did not clear global enable");

   a_gie_bit_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      global_disable_op && !(wr_en && ap_addr_q == `LIC_OFS_SYM)
      |=> system_mode_reg_q == {$past(system_mode_reg_q[7:1]), 1'b0})
      else $error("mode register changed outside bit zero");

   a_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_d.req |-> level_mask_reg_q[win_lvl] && system_mode_reg_q[`LIC_SYM_GIE])
      else $error("masked level or global disable offered");

   a_req_readonly: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 level_req_q == $past(level_pend))
      else $error("request register not following level pending");

   a_group_b_first: assert property (@(posedge hclk) disable iff (!hresetn)
      {level_priority_reg_q[`LIC_IPR_GA], level_priority_reg_q[`LIC_IPR_GB], level_priority_reg_q[`LIC_IPR_GC]} == 3'h1
      && gated[0] && gated[2] |-> win_lvl != 3'h0)
      else $error("group A beat group B under pattern 001");

   a_port4_level: assert property (@(posedge hclk) disable iff (!hresetn)
      |act_src[`LIC_NSRC-1:`LIC_L7_LO] |=> level_req_q[7])
      else $error("port 4 source did not raise level 7");

   a_timer_a_level: assert property (@(posedge hclk) disable iff (!hresetn)
      act_src[0] |=> level_req_q[0])
      else $error("timer A source did not raise level 0");

   a_stat_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
      |events |=> (stat_q & $past(events)) == $past(events))
      else $error("level event lost against status clear");

endmodule : lic_ctrl

`default_nettype wire

//--- bench/lic_src_model.sv
// Peripheral interrupt sources feeding the level controller
`timescale 1ns/1ps
`default_nettype none

module lic_src_model
   import lic_pkg::*;
(
   input wire logic hclk,        // Clock
   input wire logic hresetn,     // Async reset, active low
   input wire lic_srcv_t set_i,  // Event pulses
   input wire lic_srcv_t clr_i,  // Software pending clears
   input wire lic_srcv_t en_i,   // Peripheral interrupt enables
   output lic_src_s src_o        // Pending and enable bits
);
   lic_srcv_t pend_q;
   lic_srcv_t pend_d;

   // ----------------------------------------
   // Sticky pending bits, set wins
   // ----------------------------------------
   always_comb begin
      pend_d = (pend_q & ~clr_i) | set_i;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_d;
      end
   end

   // Source index order sets level routing and vector order
   assign src_o = '{pend: pend_q, en: en_i};
endmodule : lic_src_model
`default_nettype wire

//--- bench/test_level_interrupt_control.sv
// Self-checking bench of the level interrupt controller
`timescale 1ns/1ps
`default_nettype none

module test_level_interrupt_control;
   import lic_pkg::*;
   logic hclk, hresetn, hsel, hwrite, ge_op, gd_op, irq, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   lic_srcv_t set_v, clr_v, en_v;
   lic_src_s src;
   lic_cpu_s cpu;
   int n_mismatch = 0;
   int check_count = 0;
   int exp_win[8] = '{0, 2, 0, 2, 5, 5, 0, 0};

   lic_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hrdata(hrdata), .hresp(hresp), .src_i(src), .global_enable_op(ge_op),
      .global_disable_op(gd_op), .cpu_o(cpu), .irq_o(irq));
   lic_src_model src_u (.hclk(hclk), .hresetn(hresetn), .set_i(set_v), .clr_i(clr_v),
      .en_i(en_v), .src_o(src));

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   initial begin
      #(100 * 20000);
      n_mismatch++;
      stop_test();
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0000_00, a};
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      // Let a write reach the registered outputs before the caller looks
      repeat (2) @(posedge hclk);
   endtask : bus

   task automatic op(input logic en);
      @(posedge hclk);
      if (en) ge_op <= 1'b1;
      else gd_op <= 1'b1;
      @(posedge hclk);
      ge_op <= 1'b0;
      gd_op <= 1'b0;
      repeat (3) @(posedge hclk);
   endtask : op

   task automatic srcs(input lic_srcv_t p, input lic_srcv_t e);
      @(posedge hclk);
      set_v <= p;
      clr_v <= ~p;
      en_v <= e;
      @(posedge hclk);
      set_v <= '0;
      clr_v <= '0;
      repeat (3) @(posedge hclk);
   endtask : srcs

   task automatic stop_test();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   function automatic int lvl_of(input int i);
      if (i < 2) return 0;
      if (i < 3) return 1;
      if (i < 5) return 2;
      if (i < 9) return 3;
      if (i < 11) return 4;
      if (i < 15) return 5;
      if (i < 23) return 6;
      return 7;
   endfunction : lvl_of

   function automatic logic [7:0] vec_of(input int i);
      if (i < 9) return 8'hce + 8'(2 * i);
      if (i < 23) return 8'he4 + 8'(2 * (i - 9));
      return 8'hb0 + 8'(2 * (i - 23));
   endfunction : vec_of

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      ge_op = 1'b0;
      gd_op = 1'b0;
      set_v = '0;
      clr_v = '0;
      en_v = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a < 7; a++) begin
         bus(1'b0, 8'(4 * a), 32'h0000_0000);
         chk("reset register", rd, 32'h0000_0000);
      end
      op(1'b0);
      bus(1'b1, 8'h04, 32'h0000_00ff);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk("level mask", rd, 32'h0000_00ff);
      bus(1'b1, 8'h00, 32'h0000_00ff);
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk("request read-only", rd, 32'h0000_0000);
      bus(1'b1, 8'h18, 32'h0000_00ff);
      bus(1'b0, 8'h18, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      srcs(31'(1) << 23, '1);
      chk("req while disabled", 32'(cpu.req), 32'h0000_0000);
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk("level request", rd, 32'h0000_0080);
      op(1'b1);
      bus(1'b0, 8'h0c, 32'h0000_0000);
      chk("mode after enable", rd, 32'h0000_0001);
      chk("req enabled", 32'(cpu.req), 32'h0000_0001);
      // Interrupt output: raise, mask, clear
      bus(1'b1, 8'h14, 32'h0000_0080);
      chk("irq raised", 32'(irq), 32'h0000_0001);
      bus(1'b1, 8'h14, 32'h0000_0000);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      bus(1'b1, 8'h14, 32'h0000_0080);
      bus(1'b1, 8'h10, 32'h0000_0080);
      chk("irq cleared", 32'(irq), 32'h0000_0000);
      bus(1'b0, 8'h10, 32'h0000_0000);
      chk("status cleared", rd, 32'h0000_0000);
      // Every source alone: routing and vector
      for (int i = 0; i < 31; i++) begin
         srcs(31'(1) << i, '1);
         bus(1'b0, 8'h00, 32'h0000_0000);
         chk("route request", rd, 32'(1) << lvl_of(i));
         chk("route level", 32'(cpu.level), 32'(lvl_of(i)));
         chk("route src", 32'(cpu.src), 32'(i));
         chk("route vector", 32'(cpu.vector), 32'(vec_of(i)));
      end
      srcs((31'(1) << 24) | (31'(1) << 23), '1);
      chk("in-level winner", 32'(cpu.src), 32'd23);
      // Group order over levels 0, 2 and 5
      srcs((31'(1) << 0) | (31'(1) << 3) | (31'(1) << 11), '1);
      for (int p = 0; p < 8; p++) begin
         bus(1'b1, 8'h08, {24'h0000_00, p[2], 2'b00, p[1], 2'b00, p[0], 1'b0});
         chk("group winner", 32'(cpu.level), 32'(exp_win[p]));
      end
      srcs((31'(1) << 0) | (31'(1) << 2), '1);
      bus(1'b1, 8'h08, 32'h0000_0001);
      chk("level 1 first", 32'(cpu.level), 32'h0000_0001);
      bus(1'b1, 8'h08, 32'h0000_0000);
      chk("level 0 first", 32'(cpu.level), 32'h0000_0000);
      // Subgroup order inside groups B and C
      srcs((31'(1) << 3) | (31'(1) << 5) | (31'(1) << 9), '1);
      bus(1'b1, 8'h08, 32'h0000_0002);
      chk("level 2 first", 32'(cpu.level), 32'h0000_0002);
      bus(1'b1, 8'h08, 32'h0000_0006);
      chk("level 3 first", 32'(cpu.level), 32'h0000_0003);
      bus(1'b1, 8'h08, 32'h0000_000e);
      chk("level 4 first", 32'(cpu.level), 32'h0000_0004);
      srcs((31'(1) << 11) | (31'(1) << 15) | (31'(1) << 23), '1);
      bus(1'b1, 8'h08, 32'h0000_0082);
      chk("level 5 first", 32'(cpu.level), 32'h0000_0005);
      bus(1'b1, 8'h08, 32'h0000_00a2);
      chk("level 6 first", 32'(cpu.level), 32'h0000_0006);
      bus(1'b1, 8'h08, 32'h0000_00e2);
      chk("level 7 first", 32'(cpu.level), 32'h0000_0007);
      // Level 0 masked beside level 7, which already ranks first under 0xe2
      srcs((31'(1) << 0) | (31'(1) << 23), '1);
      op(1'b0);
      bus(1'b1, 8'h04, 32'h0000_00fe);
      op(1'b1);
      chk("masked level", 32'(cpu.level), 32'h0000_0007);
      srcs(31'(1) << 0, '0);
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk("source disabled", rd, 32'h0000_0000);
      chk("no req", 32'(cpu.req), 32'h0000_0000);
      srcs(31'(1) << 23, '1);
      op(1'b0);
      chk("req after disable", 32'(cpu.req), 32'h0000_0000);
      bus(1'b0, 8'h0c, 32'h0000_0000);
      chk("mode after disable", rd, 32'h0000_0000);
      bus(1'b1, 8'h0c, 32'h0000_00a5);
      bus(1'b0, 8'h0c, 32'h0000_0000);
      chk("mode read-write", rd, 32'h0000_00a5);
      // Both ops in one cycle: disable wins, other mode bits kept
      @(posedge hclk);
      ge_op <= 1'b1;
      gd_op <= 1'b1;
      @(posedge hclk);
      ge_op <= 1'b0;
      gd_op <= 1'b0;
      bus(1'b0, 8'h0c, 32'h0000_0000);
      chk("disable wins", rd, 32'h0000_00a4);
      chk("req after both ops", 32'(cpu.req), 32'h0000_0000);
      chk("bus response", 32'(hresp), 32'h0000_0000);
      chk("bus ready", 32'(hready), 32'h0000_0001);
      stop_test();
   end
endmodule : test_level_interrupt_control
`default_nettype wire
